/* link_ctl_pkg.sv */
package link_ctl_pkg;
    // field positions of the upper control word
    localparam int BIT_CYC_MASTER = 20;
    localparam int BIT_CYC_SOURCE = 21;
    localparam int BIT_CYC_TIMER  = 22;
    localparam int BIT_SID_CLEAR  = 23;
    localparam int BIT_AUTO_ROOT  = 28;
    localparam int BIT_ISO_PORT1  = 29;
    localparam int BIT_ISO_PORT2  = 30;
    localparam logic [19:0] LOWER_FIELDS = 20'h00000;
    localparam logic [31:0] RDATA_RESET  = 32'h00000000;

    // cycle timer limits
    localparam logic [11:0] CYC_OFFSET_MAX = 12'hBFF;
    localparam logic [12:0] CYC_COUNT_MAX  = 13'h1F3F;

    // self-id error codes
    localparam logic [3:0] SID_OK        = 4'h0;
    localparam logic [3:0] SID_NOT_CHILD = 4'h1;
    localparam logic [3:0] SID_BAD_ID    = 4'h2;
    localparam logic [3:0] SID_PHASE     = 4'h3;
    localparam logic [3:0] SID_MULTI_GAP = 4'h4;
    localparam logic [3:0] SID_BIG_GAP   = 4'h5;
    localparam logic [3:0] SID_PKT_ID    = 4'h6;
    localparam logic [3:0] SID_NOT_INV   = 4'h7;

    // self-id quadlet layout
    localparam logic [1:0] SID_TAG     = 2'h2;
    localparam logic [1:0] PORT_PARENT = 2'h2;
    localparam int SID_TAG_HI  = 31;
    localparam int SID_TAG_LO  = 30;
    localparam int SID_ID_HI   = 29;
    localparam int SID_ID_LO   = 24;
    localparam int SID_EXT_BIT = 23;
    localparam int PORT0_LO    = 6;
    localparam int PORT1_LO    = 4;
    localparam int PORT2_LO    = 2;

    typedef struct packed {
        logic        start;  // bus reset: self-id phase begins
        logic        valid;  // one received self-id quadlet
        logic [31:0] quad;
        logic        done;   // self-id phase ended
    } selfid_in_t;

    typedef struct packed {
        logic       valid;   // header of an isochronous packet
        logic [5:0] chan;
    } iso_hdr_t;

    typedef enum logic {SID_DATA, SID_INV} sid_state_t;
endpackage : link_ctl_pkg

/* link_ctl.sv */
// How it works
// - master enabled and root: cycle-start request on every cycle_count step
// - source select set: external rising edge steps count, zeroes offset
// - source select clear: count steps when offset rolls over
// - offset advances only while the timer enable is set, else holds unless zeroed by an external edge
// - writing the clear bit zeroes the error code unless a new error is detected in the clear cycle; clear bit self-clears
// - error code keeps the first error; 0 none, 1 last not all child
// - code 2 when a physical id is below the expected next id
// - code 3 when a quadlet is out of phase in a pair
// - code 4 for two or more id gaps, code 5 for one large gap
// - code 6 for id mismatch inside a packet, 7 for bad inversion
// - auto bit set and node root after bus reset: set master enable
// - port 1 enabled: accept iso packets matching port 1 channel
// - port 2 enabled: accept iso packets matching port 2 channel
`timescale 1ns/1ps
module link_ctl
    import link_ctl_pkg::*;
(
    input  wire logic        clk,           // 125 MHz
    input  wire logic        rst_n,         // synchronous, active low
    input  wire logic        reg_wr,        // write strobe, one cycle
    input  wire logic [31:0] reg_wdata,     // write data
    output logic      [31:0] reg_rdata,     // register read value
    input  wire logic        is_root,       // attached phy is root
    input  wire logic        bus_reset_done,// pulse: bus reset finished
    input  wire logic        cyc_tick,      // pulse: link cycle clock
    input  wire logic        cycle_in,      // external cycle input
    output logic      [11:0] cycle_offset,  // cycle timer offset
    output logic      [12:0] cycle_count,   // cycle timer count
    output logic             cycle_start,   // pulse: send cycle-start
    input  selfid_in_t       selfid,        // self-id quadlet stream
    input  iso_hdr_t         iso_hdr,       // iso packet header
    input  wire logic  [5:0] port1_channel, // channel for port 1
    input  wire logic  [5:0] port2_channel, // channel for port 2
    output logic             iso_accept1,   // pulse: port 1 takes packet
    output logic             iso_accept2,   // pulse: port 2 takes packet
    output logic             cycle_master_enable, // current master bit
    output logic       [3:0] selfid_err_code      // latched error code
);
    logic        cm_q, src_q, ten_q, auto_q, irp1_q, irp2_q, clr_q;
    logic [3:0]  code_q;
    logic [11:0] off_q, off_d;
    logic [12:0] cnt_q, cnt_d;
    logic        ext_q, start_q, acc1_q, acc2_q;
    logic [31:0] rdata_q;
    sid_state_t  st_q;
    logic [31:0] prev_q, last0_q;
    logic [5:0]  pkt_id_q, exp_id_q;
    logic        gap_q;

    // ---------------- control bits ----------------
    wire auto_set = auto_q & bus_reset_done & is_root;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cm_q   <= 1'b0;
            src_q  <= 1'b0;
            ten_q  <= 1'b0;
            auto_q <= 1'b0;
            irp1_q <= 1'b0;
            irp2_q <= 1'b0;
            clr_q  <= 1'b0;
        end else begin
            // hardware set beats a software write in the same cycle
            if (auto_set)
                cm_q <= 1'b1;
            else if (reg_wr)
                cm_q <= reg_wdata[BIT_CYC_MASTER];
            if (reg_wr) begin
                src_q  <= reg_wdata[BIT_CYC_SOURCE];
                ten_q  <= reg_wdata[BIT_CYC_TIMER];
                auto_q <= reg_wdata[BIT_AUTO_ROOT];
                irp1_q <= reg_wdata[BIT_ISO_PORT1];
                irp2_q <= reg_wdata[BIT_ISO_PORT2];
            end
            clr_q <= reg_wr & reg_wdata[BIT_SID_CLEAR];
        end
    end

    // ---------------- cycle timer ----------------
    wire ext_rise = cycle_in & ~ext_q;
    wire off_step = ten_q & cyc_tick;
    wire off_wrap = off_step & (off_q == CYC_OFFSET_MAX);
    wire cnt_inc  = src_q ? ext_rise : off_wrap;
    wire cnt_wrap = (cnt_q == CYC_COUNT_MAX);

    always_comb begin
        off_d = off_q;
        if (src_q && ext_rise)
            off_d = '0;
        else if (off_wrap)
            off_d = '0;
        else if (off_step)
            off_d = off_q + 12'h001;
        cnt_d = cnt_q;
        if (cnt_inc)
            cnt_d = cnt_wrap ? '0 : cnt_q + 13'h0001;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ext_q   <= 1'b0;
            off_q   <= '0;
            cnt_q   <= '0;
            start_q <= 1'b0;
        end else begin
            ext_q   <= cycle_in;
            off_q   <= off_d;
            cnt_q   <= cnt_d;
            start_q <= cnt_inc & cm_q & is_root;
        end
    end

    // ---------------- self-id checker ----------------
    wire [5:0] q_id     = selfid.quad[SID_ID_HI:SID_ID_LO];
    wire       q_ext    = selfid.quad[SID_EXT_BIT];
    wire       q_tag_ok = selfid.quad[SID_TAG_HI:SID_TAG_LO] == SID_TAG;
    wire [6:0] id_w     = {1'b0, q_id};
    wire [6:0] exp_w    = {1'b0, exp_id_q};
    wire       id_low   = id_w < exp_w;
    wire       id_gap   = id_w == exp_w + 7'h01;
    wire       id_big   = id_w > exp_w + 7'h01;
    wire       data_in  = selfid.valid & (st_q == SID_DATA);
    wire       inv_in   = selfid.valid & (st_q == SID_INV);
    wire       parent_seen =
        (last0_q[PORT0_LO +: 2] == PORT_PARENT) |
        (last0_q[PORT1_LO +: 2] == PORT_PARENT) |
        (last0_q[PORT2_LO +: 2] == PORT_PARENT);

    // priority among checks of one quadlet; code 8 is never produced
    wire [3:0] data_code =
        !q_tag_ok                    ? SID_PHASE     :
        q_ext                        ? ((q_id != pkt_id_q) ?
                                        SID_PKT_ID : SID_OK) :
        id_low                       ? SID_BAD_ID    :
        id_big                       ? SID_BIG_GAP   :
        (id_gap && gap_q)            ? SID_MULTI_GAP :
                                       SID_OK;
    wire [3:0] det_code =
        data_in                             ? data_code   :
        (inv_in && selfid.quad != ~prev_q)  ? SID_NOT_INV :
        (selfid.done && parent_seen)        ? SID_NOT_CHILD:
                                              SID_OK;
    wire det_err = det_code != SID_OK;

    always_ff @(posedge clk) begin
        if (!rst_n || selfid.start) begin
            st_q     <= SID_DATA;
            exp_id_q <= '0;
            pkt_id_q <= '0;
            gap_q    <= 1'b0;
            prev_q   <= '0;
            last0_q  <= '0;
        end else if (data_in) begin
            st_q   <= SID_INV;
            prev_q <= selfid.quad;
            if (!q_ext) begin
                pkt_id_q <= q_id;
                exp_id_q <= q_id + 6'h01;
                last0_q  <= selfid.quad;
                if (id_gap)
                    gap_q <= 1'b1;
            end
        end else if (inv_in) begin
            st_q <= SID_DATA;
        end
    end

    // first error wins; a new error in the clear cycle is kept
    always_ff @(posedge clk) begin
        if (!rst_n)
            code_q <= SID_OK;
        else if (det_err && (code_q == SID_OK || clr_q))
            code_q <= det_code;
        else if (clr_q)
            code_q <= SID_OK;
    end

    // ---------------- iso channel filter ----------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            acc1_q <= 1'b0;
            acc2_q <= 1'b0;
        end else begin
            acc1_q <= iso_hdr.valid & irp1_q &
                      (iso_hdr.chan == port1_channel);
            acc2_q <= iso_hdr.valid & irp2_q &
                      (iso_hdr.chan == port2_channel);
        end
    end

    // ---------------- read-back ----------------
    // clear bit is write-only and lower fields live elsewhere: read 0
    wire [31:0] rd_word = {1'b0, irp2_q, irp1_q, auto_q, code_q,
                           1'b0, ten_q, src_q, cm_q, LOWER_FIELDS};

    always_ff @(posedge clk) begin
        if (!rst_n)
            rdata_q <= RDATA_RESET;
        else
            rdata_q <= rd_word;
    end

    assign reg_rdata           = rdata_q;
    assign cycle_offset        = off_q;
    assign cycle_count         = cnt_q;
    assign cycle_start         = start_q;
    assign iso_accept1         = acc1_q;
    assign iso_accept2         = acc2_q;
    assign cycle_master_enable = cm_q;
    assign selfid_err_code     = code_q;

    // ---------------- assertions ----------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_clear_write;
        reg_wr && reg_wdata[BIT_SID_CLEAR] ##1 !det_err;
    endsequence

    a_clear_zeroes: assert property (s_clear_write |=> code_q == SID_OK)
        else $error("error code not cleared");

    a_clear_self: assert property (clr_q && !reg_wr |=> !clr_q)
        else $error("clear bit did not return to zero");

    a_first_kept: assert property (code_q != SID_OK && !clr_q
        |=> code_q == $past(code_q))
        else $error("first error code overwritten");

    a_err_latch: assert property (det_err && code_q == SID_OK
        |=> code_q == $past(det_code))
        else $error("detected error not latched");

    a_timer_hold: assert property (!ten_q && !(src_q && ext_rise)
        |=> off_q == $past(off_q))
        else $error("offset moved while timer disabled");

    a_ext_edge: assert property (src_q && ext_rise
        |=> off_q == 12'h000 && cnt_q != $past(cnt_q))
        else $error("external edge did not step the count");

    a_count_roll: assert property (!src_q && !off_wrap
        |=> cnt_q == $past(cnt_q))
        else $error("count stepped without roll-over");

    a_cycle_start: assert property (cnt_inc && cm_q && is_root
        |=> cycle_start ##1
            (!cycle_start || $past(cnt_inc && cm_q && is_root)))
        else $error("cycle-start request missing");

    a_auto_master: assert property (auto_set |=> cycle_master_enable)
        else $error("auto master enable not set");

    a_iso_ports: assert property (iso_hdr.valid && irp1_q
        && iso_hdr.chan == port1_channel |=> iso_accept1)
        else $error("port 1 did not accept matching packet");

    a_rsvd_zero: assert property (##1 reg_rdata[31] == 1'b0)
        else $error("reserved bit reads one");
endmodule : link_ctl

/* host_model.sv */
`timescale 1ns/1ps
module host_model (
    input  wire logic        clk,       // register clock
    output logic             reg_wr,    // write strobe
    output logic      [31:0] reg_wdata  // write data
);
    initial begin
        reg_wr    = 1'b0;
        reg_wdata = 32'h00000000;
    end
    // one write with bit 31 forced to 0; the strobe drops for a cycle between writes
    task automatic wr(input logic [31:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_wdata <= {1'b0, d[30:0]};
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : wr
endmodule : host_model

/* tb.sv */
`timescale 1ns/1ps
module tb;
    import link_ctl_pkg::*;
    logic clk = 0, rst_n = 0, is_root = 0, bus_reset_done = 0;
    logic cyc_tick = 0, cycle_in = 0;
    logic [5:0] p1 = 0, p2 = 0, ch;
    selfid_in_t selfid = '0;
    iso_hdr_t   iso_hdr = '0;
    logic reg_wr, cs, a1, a2, mas;
    logic [31:0] reg_wdata, reg_rdata, w, en;
    logic [11:0] off;
    logic [12:0] cnt;
    logic [3:0] code;
    // reserved code 8 is never expected from the checker
    logic [3:0] ec [7] = '{SID_NOT_INV, SID_PHASE, SID_BIG_GAP,
                           SID_BAD_ID, SID_MULTI_GAP, SID_PKT_ID,
                           SID_NOT_CHILD};
    int num_errors = 0, n_tests = 0, cyc = 0, seed = 12;
    localparam logic [31:0] RW_MASK = 32'h70700000;

    always #4 clk = ~clk;

    host_model host (.clk(clk), .reg_wr(reg_wr), .reg_wdata(reg_wdata));
    link_ctl i_link_ctl (
        .clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .is_root(is_root),
        .bus_reset_done(bus_reset_done), .cyc_tick(cyc_tick),
        .cycle_in(cycle_in), .cycle_offset(off), .cycle_count(cnt),
        .cycle_start(cs), .selfid(selfid), .iso_hdr(iso_hdr),
        .port1_channel(p1), .port2_channel(p2), .iso_accept1(a1),
        .iso_accept2(a2), .cycle_master_enable(mas),
        .selfid_err_code(code));

    task automatic chk(input logic [31:0] g, e, input string m);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask : chk
    task automatic give_verdict();
        $display("errors %0d comparisons %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : give_verdict
    task automatic tk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tk
    task automatic ticks(input int n);
        @(posedge clk);
        cyc_tick <= 1'b1;
        repeat (n) @(posedge clk);
        cyc_tick <= 1'b0;
        #1;
    endtask : ticks
    task automatic sq(input logic s, v, d, input logic [31:0] q);
        @(posedge clk);
        selfid <= {s, v, q, d};
    endtask : sq
    task automatic pr(input logic [31:0] q, i);
        sq(1'b0, 1'b1, 1'b0, q);
        sq(1'b0, 1'b1, 1'b0, i);
    endtask : pr
    task automatic pq(input logic [5:0] id);
        pr({SID_TAG, id, 24'h000000}, ~{SID_TAG, id, 24'h000000});
    endtask : pq

    // hang guard, well above the few thousand cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc > 8000) begin
            num_errors++;
            give_verdict();
        end
    end

    initial begin
        repeat (3) @(posedge clk);
        rst_n   <= 1'b1;
        is_root <= 1'b1;
        tk(1);
        chk(reg_rdata, RDATA_RESET, "reset read");
        chk(code, SID_OK, "reset code");
        for (int i = 0; i < 4; i++) begin
            w = $random(seed);
            host.wr(w);
            tk(2);
            chk(reg_rdata, w & RW_MASK, "readback");
        end
        host.wr(32'h00400000);
        ticks(5);
        chk(off, 5, "offset count");
        host.wr(32'h00000000);
        ticks(3);
        chk(off, 5, "offset hold");
        host.wr(32'h00500000);
        ticks(3066);
        chk(off, 12'hBFF, "offset top");
        ticks(1);
        chk(off, 0, "offset wrap");
        chk(cnt, 1, "count step");
        chk(cs, 1, "start pulse");
        tk(1);
        chk(cs, 0, "start end");
        host.wr(32'h00600000);
        ticks(7);
        @(posedge clk) cycle_in <= 1'b1;
        tk(1);
        chk(off, 0, "ext zero");
        chk(cnt, 2, "ext step");
        chk(cs, 0, "no master");
        @(posedge clk) cycle_in <= 1'b0;
        host.wr(32'h10000000);
        tk(1);
        chk(mas, 0, "auto idle");
        // random root state first, then its opposite: both gates exercised
        w = $random(seed);
        for (int j = 0; j < 2; j++) begin
            @(posedge clk) begin
                is_root        <= w[0] ^ j[0];
                bus_reset_done <= 1'b1;
            end
            @(posedge clk) bus_reset_done <= 1'b0;
            #1;
            chk(mas, w[0] | j[0], "auto set");
        end
        @(posedge clk) is_root <= 1'b1;
        @(posedge clk) begin
            w = $random(seed);
            p1 <= w[5:0];
            p2 <= w[5:0] ^ 6'h2A;
        end
        for (int k = 0; k < 4; k++) begin
            en = (k < 3) ? 32'h60000000 : 32'h20000000;
            ch = (k == 0) ? p1 : (k == 2) ? p1 ^ 6'h01 : p2;
            host.wr(en);
            @(posedge clk) iso_hdr <= {1'b1, ch};
            @(posedge clk) iso_hdr <= '0;
            #1;
            chk(a1, en[29] && ch == p1, "port1");
            chk(a2, en[30] && ch == p2, "port2");
        end
        for (int c = 0; c < 7; c++) begin
            sq(1'b1, 1'b0, 1'b0, 32'h0);
            case (c)
                0: begin
                    pq(0);
                    pr(32'h81000000, 32'h81000000);
                end
                1: pr(32'h00000000, 32'hFFFFFFFF);
                2: begin
                    pq(0);
                    pq(3);
                    pq(0);
                end
                3: begin
                    pq(0);
                    pq(0);
                end
                4: begin
                    pq(0);
                    pq(2);
                    pq(4);
                end
                5: begin
                    pq(0);
                    pr({SID_TAG, 6'h05, 1'b1, 23'h000000},
                       ~{SID_TAG, 6'h05, 1'b1, 23'h000000});
                end
                default: begin
                    pr(32'h80000080, 32'h7FFFFF7F);
                    sq(1'b0, 1'b0, 1'b1, 32'h0);
                end
            endcase
            sq(1'b0, 1'b0, 1'b0, 32'h0);
            tk(0);
            chk(code, ec[c], "error code");
            host.wr(32'h00800000);
            tk(1);
            chk(code, SID_OK, "code clear");
        end
        give_verdict();
    end
endmodule : tb
